// ### design/ccu_unit.sv
// Capture/compare/PWM unit with a classic Wishbone register slave.
//
// Chosen here: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none

module ccu_unit #(
    parameter bit SECOND_UNIT = 1'b0
) (
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic                ce_i,
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [7:0]          wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic      [31:0]         wb_dat_o,
    output logic                     wb_ack_o,
    input  wire logic [15:0]         timebase_i,
    input  wire logic                adc_enabled_i,
    output logic                     timebase_clear_o,
    output logic                     adc_start_o,
    output logic                     irq_o,
    input  wire logic                pin_i,
    output logic                     pin_o,
    output logic                     pin_oe_o
);
    import ccu_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic [7:0]  ctrl_r;
    logic [7:0]  val_lo_r;
    logic [7:0]  val_hi_r;
    logic        flag_r;
    logic        ien_r;
    logic [7:0]  period_r;
    logic [7:0]  pinreg_r;
    logic        ack_r;
    logic [31:0] rdat_r;
    logic        sync1_r;
    logic        sync2_r;
    logic        lvl_prev_r;
    logic [3:0]  pscnt_r;
    logic        matched_r;
    logic        out_r;
    logic        trig_r;
    logic        adc_r;
    logic [7:0]  tmr8_r;
    logic [1:0]  phase_r;
    logic [9:0]  duty_buf_r;

    wire logic [3:0] mode      = ctrl_r[CCU_CTRL_MODE_MSB:CCU_CTRL_MODE_LSB];
    wire logic       is_off    = (mode == CCU_MODE_OFF);
    wire logic       is_cap    = (mode[3:2] == 2'b01);
    wire logic       is_cmp    = (mode[3:2] == 2'b10);
    wire logic       is_pwm    = (mode[3:2] == 2'b11);
    wire logic       pin_input = pinreg_r[CCU_PIN_DIR];
    wire logic       tb_on     = pinreg_r[CCU_PIN_TB_ON];

    // Bus decode.
    wire logic       wb_req   = wb_cyc_i & wb_stb_i;
    wire logic       wr_cmt   = wb_req & ack_r & wb_we_i & wb_sel_i[0] & ce_i;
    wire logic [7:0] wr_byte  = wb_dat_i[7:0];
    wire logic       wr_ctrl  = wr_cmt & (wb_adr_i == CCU_OFF_CTRL);
    wire logic       wr_vallo = wr_cmt & (wb_adr_i == CCU_OFF_VALLO);
    wire logic       wr_valhi = wr_cmt & (wb_adr_i == CCU_OFF_VALHI) & ~is_pwm;
    wire logic       wr_flag  = wr_cmt & (wb_adr_i == CCU_OFF_FLAG);
    wire logic       wr_ien   = wr_cmt & (wb_adr_i == CCU_OFF_IEN);
    wire logic       wr_per   = wr_cmt & (wb_adr_i == CCU_OFF_PERIOD);
    wire logic       wr_pin   = wr_cmt & (wb_adr_i == CCU_OFF_PIN);

    wire logic [7:0] rd_byte =
        (wb_adr_i == CCU_OFF_CTRL)   ? {2'b00, ctrl_r[5:0]} :
        (wb_adr_i == CCU_OFF_VALLO)  ? val_lo_r :
        (wb_adr_i == CCU_OFF_VALHI)  ? val_hi_r :
        (wb_adr_i == CCU_OFF_FLAG)   ? (8'h00 | ({7'h00, flag_r} << CCU_FLAG_EVENT)) :
        (wb_adr_i == CCU_OFF_IEN)    ? (8'h00 | ({7'h00, ien_r} << CCU_IEN_EVENT)) :
        (wb_adr_i == CCU_OFF_PERIOD) ? period_r :
        (wb_adr_i == CCU_OFF_PIN)    ? {5'h00, pinreg_r[2:0]} :
        (wb_adr_i == CCU_OFF_PWMTB)  ? tmr8_r : 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Pin level seen by the edge detector; an output pin follows its own drive.
    wire logic pin_drv = (is_cmp | is_pwm) ? out_r : pinreg_r[CCU_PIN_DATA];
    wire logic lvl     = pin_input ? sync2_r : pin_drv;
    wire logic rise    = lvl & ~lvl_prev_r;
    wire logic fall    = ~lvl & lvl_prev_r;

    wire logic cap_ev  = ((mode == CCU_MODE_CAPF)  & fall) |
                         ((mode == CCU_MODE_CAPR)  & rise) |
                         ((mode == CCU_MODE_CAP16) & rise & (pscnt_r == CCU_PS_LAST16)) |
                         ((mode == CCU_MODE_CAP4)  & rise & (pscnt_r[1:0] == CCU_PS_LAST4));

    // Compare fires once per timebase value, even with the timebase stopped.
    wire logic tb_eq   = (timebase_i == {val_hi_r, val_lo_r});
    wire logic cmp_ev  = is_cmp & tb_eq & ~matched_r;
    wire logic trig_ev = cmp_ev & (mode == CCU_MODE_CMPTRG);

    // PWM timer steps once per four phase counts.
    wire logic tmr_step = is_pwm & tb_on & (phase_r == CCU_PH_LAST);
    wire logic per_end  = tmr_step & (tmr8_r == period_r);
    wire logic [9:0] duty_new = {val_lo_r, ctrl_r[CCU_CTRL_DUTY_MSB:CCU_CTRL_DUTY_LSB]};
    // The latch is registered, so the next count is matched and the high time is exactly the duty value.
    wire logic [9:0] pwm_pos_nxt = {tmr8_r, phase_r} + 10'h001;
    wire logic duty_hit = is_pwm & tb_on & (pwm_pos_nxt == duty_buf_r);

    wire logic ctrl_zero = wr_ctrl & (wr_byte == 8'h00);

    ////////////////////////////////////////////////////////////////////////
    // Bus slave: ack one cycle after the request, commit on the ack edge.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r  <= 1'b0;
            rdat_r <= 32'h0000_0000;
        end else if (ce_i) begin
            ack_r  <= wb_req & ~ack_r;
            rdat_r <= {24'h00_0000, rd_byte};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r   <= CCU_RST_CTRL;
            ien_r    <= 1'b0;
            period_r <= CCU_RST_PERIOD;
            pinreg_r <= CCU_RST_PIN;
        end else if (ce_i) begin
            if (wr_ctrl) ctrl_r   <= {2'b00, wr_byte[5:0]};
            if (wr_ien)  ien_r    <= wr_byte[CCU_IEN_EVENT];
            if (wr_per)  period_r <= wr_byte;
            if (wr_pin)  pinreg_r <= {5'h00, wr_byte[2:0]};
        end
    end

    // Value register: capture overwrites without any overrun mark.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            val_lo_r <= CCU_RST_VAL;
            val_hi_r <= CCU_RST_VAL;
        end else if (ce_i) begin
            if (is_cap & cap_ev) begin
                val_lo_r <= timebase_i[7:0];
                val_hi_r <= timebase_i[15:8];
            end else begin
                if (wr_vallo) val_lo_r <= wr_byte;
                if (wr_valhi) val_hi_r <= wr_byte;
                if (per_end)  val_hi_r <= val_lo_r;
            end
        end
    end

    // Event flag: a hardware set wins over a software clear in the same cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_r <= 1'b0;
        end else if (ce_i) begin
            if ((is_cap & cap_ev) | cmp_ev) flag_r <= 1'b1;
            else if (wr_flag)               flag_r <= wr_byte[CCU_FLAG_EVENT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_r    <= 1'b0;
            sync2_r    <= 1'b0;
            lvl_prev_r <= 1'b0;
        end else if (ce_i) begin
            sync1_r    <= pin_i;
            sync2_r    <= sync1_r;
            lvl_prev_r <= lvl;
        end
    end

    // Prescaler keeps counting across capture-to-capture mode switches.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pscnt_r <= 4'h0;
        end else if (ce_i) begin
            if (!is_cap)   pscnt_r <= 4'h0;
            else if (rise) pscnt_r <= pscnt_r + 4'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            matched_r <= 1'b0;
            trig_r    <= 1'b0;
            adc_r     <= 1'b0;
        end else if (ce_i) begin
            matched_r <= is_cmp & tb_eq;
            trig_r    <= trig_ev;
            adc_r     <= trig_ev & SECOND_UNIT & adc_enabled_i;
        end
    end

    // Output latch shared by compare and PWM.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_r <= 1'b0;
        end else if (ce_i) begin
            if (ctrl_zero | is_off)                              out_r <= 1'b0;
            else if (cmp_ev & (mode == CCU_MODE_CMPHI))          out_r <= 1'b1;
            else if (cmp_ev & (mode == CCU_MODE_CMPLO))          out_r <= 1'b0;
            else if (per_end)                                    out_r <= (duty_new != 10'h000);
            else if (duty_hit)                                   out_r <= 1'b0;
        end
    end

    // PWM timebase and double-buffered duty.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tmr8_r     <= 8'h00;
            phase_r    <= 2'h0;
            duty_buf_r <= 10'h000;
        end else if (ce_i) begin
            if (!is_pwm) begin
                tmr8_r     <= 8'h00;
                phase_r    <= 2'h0;
                duty_buf_r <= 10'h000;
            end else if (tb_on) begin
                phase_r <= phase_r + 2'h1;
                if (per_end) begin
                    tmr8_r     <= 8'h00;
                    duty_buf_r <= duty_new;
                end else if (tmr_step) begin
                    tmr8_r <= tmr8_r + 8'h01;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Timebase clear is a separate strobe so the timer does not see a wrap.
    assign timebase_clear_o = trig_r;
    assign adc_start_o      = adc_r;
    assign irq_o            = flag_r & ien_r;
    assign pin_o            = pin_drv;
    assign pin_oe_o         = ~pin_input;
    assign wb_ack_o         = ack_r;
    assign wb_dat_o         = rdat_r;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_rise_capture;
        ce_i && (mode == CCU_MODE_CAPR) && rise;
    endsequence

    property p_capture_value;
        s_rise_capture |=> ({val_hi_r, val_lo_r} == $past(timebase_i));
    endproperty
    a_capture_value: assert property (p_capture_value) else $error("capture lost timebase");

    property p_capture_flag;
        s_rise_capture |=> flag_r;
    endproperty
    a_capture_flag: assert property (p_capture_flag) else $error("capture flag not set");

    property p_flag_sticky;
        (flag_r && !wr_flag) |=> flag_r;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped alone");

    property p_ps_clear;
        (ce_i && !is_cap) |=> (pscnt_r == 4'h0);
    endproperty
    a_ps_clear: assert property (p_ps_clear) else $error("prescaler not cleared");

    property p_cap4;
        (ce_i && (mode == CCU_MODE_CAP4) && rise && (pscnt_r[1:0] != CCU_PS_LAST4) && !wr_vallo)
            |=> $stable(val_lo_r);
    endproperty
    a_cap4: assert property (p_cap4) else $error("early quarter capture");

    property p_cmp_high;
        (cmp_ev && ce_i && (mode == CCU_MODE_CMPHI) && !wr_ctrl) |=> (out_r && flag_r);
    endproperty
    a_cmp_high: assert property (p_cmp_high) else $error("compare high failed");

    property p_cmp_once;
        (ce_i && cmp_ev) |=> !cmp_ev;
    endproperty
    a_cmp_once: assert property (p_cmp_once) else $error("double compare match");

    sequence s_trig;
        ce_i && trig_ev;
    endsequence

    property p_trig;
        s_trig |=> timebase_clear_o ##1 !timebase_clear_o || $past(trig_ev);
    endproperty
    a_trig: assert property (p_trig) else $error("trigger pulse wrong");

    property p_pin_keep;
        (ce_i && cmp_ev && (mode == CCU_MODE_CMPIRQ) && !wr_ctrl) |=> $stable(out_r);
    endproperty
    a_pin_keep: assert property (p_pin_keep) else $error("pin moved in flag mode");

    property p_zero_ctrl;
        (ctrl_zero) |=> (!out_r && (ctrl_r == 8'h00));
    endproperty
    a_zero_ctrl: assert property (p_zero_ctrl) else $error("latch not forced low");

    property p_period;
        (ce_i && per_end) |=> (tmr8_r == 8'h00) && (duty_buf_r == $past(duty_new));
    endproperty
    a_period: assert property (p_period) else $error("period end mishandled");

    property p_cmp_low;
        (cmp_ev && ce_i && (mode == CCU_MODE_CMPLO) && !wr_ctrl) |=> (!out_r && flag_r);
    endproperty
    a_cmp_low: assert property (p_cmp_low) else $error("compare low failed");

    property p_ps_keep;
        (ce_i && is_cap && !rise) |=> $stable(pscnt_r);
    endproperty
    a_ps_keep: assert property (p_ps_keep) else $error("prescaler lost its count");

    property p_adc;
        s_trig |=> (adc_start_o == (SECOND_UNIT && $past(adc_enabled_i)));
    endproperty
    a_adc: assert property (p_adc) else $error("conversion start wrong");

    property p_duty_clear;
        (ce_i && duty_hit && !per_end) |=> !out_r;
    endproperty
    a_duty_clear: assert property (p_duty_clear) else $error("duty match kept output");

    property p_period_set;
        (ce_i && per_end && !wr_ctrl) |=> (out_r == ($past(duty_new) != 10'h000));
    endproperty
    a_period_set: assert property (p_period_set) else $error("period start level wrong");

    property p_off_state;
        (ce_i && is_off) |=> (!out_r && (tmr8_r == 8'h00) && (pscnt_r == 4'h0));
    endproperty
    a_off_state: assert property (p_off_state) else $error("off mode kept state");

    // An edge must come from the second stage, never straight from the pin.
    property p_sync;
        (ce_i && $past(ce_i) && pin_input && rise) |-> $past(sync1_r);
    endproperty
    a_sync: assert property (p_sync) else $error("edge bypassed synchronizer");

endmodule : ccu_unit

`default_nettype wire

// ### design/ccu_pkg.sv
// Constants shared by the capture/compare/PWM unit and its bench.
package ccu_pkg;
    // Register byte addresses on the bus.
    localparam logic [7:0] CCU_OFF_CTRL   = 8'h00;
    localparam logic [7:0] CCU_OFF_VALLO  = 8'h04;
    localparam logic [7:0] CCU_OFF_VALHI  = 8'h08;
    localparam logic [7:0] CCU_OFF_FLAG   = 8'h0C;
    localparam logic [7:0] CCU_OFF_IEN    = 8'h10;
    localparam logic [7:0] CCU_OFF_PERIOD = 8'h14;
    localparam logic [7:0] CCU_OFF_PIN    = 8'h18;
    localparam logic [7:0] CCU_OFF_PWMTB  = 8'h1C;

    // Field positions.
    localparam int CCU_CTRL_MODE_LSB = 0;
    localparam int CCU_CTRL_MODE_MSB = 3;
    localparam int CCU_CTRL_DUTY_LSB = 4;
    localparam int CCU_CTRL_DUTY_MSB = 5;
    localparam int CCU_FLAG_EVENT    = 2;
    localparam int CCU_IEN_EVENT     = 2;
    localparam int CCU_PIN_DIR       = 0;
    localparam int CCU_PIN_DATA      = 1;
    localparam int CCU_PIN_TB_ON     = 2;

    // Reset values.
    localparam logic [7:0] CCU_RST_CTRL   = 8'h00;
    localparam logic [7:0] CCU_RST_VAL    = 8'h00;
    localparam logic [7:0] CCU_RST_PERIOD = 8'hFF;
    localparam logic [7:0] CCU_RST_PIN    = 8'h01;

    // Mode codes.
    localparam logic [3:0] CCU_MODE_OFF    = 4'h0;
    localparam logic [3:0] CCU_MODE_CAPF   = 4'h4;
    localparam logic [3:0] CCU_MODE_CAPR   = 4'h5;
    localparam logic [3:0] CCU_MODE_CAP16  = 4'h6;
    localparam logic [3:0] CCU_MODE_CAP4   = 4'h7;
    localparam logic [3:0] CCU_MODE_CMPHI  = 4'h8;
    localparam logic [3:0] CCU_MODE_CMPLO  = 4'h9;
    localparam logic [3:0] CCU_MODE_CMPIRQ = 4'hA;
    localparam logic [3:0] CCU_MODE_CMPTRG = 4'hB;

    // Prescaler terminal counts and PWM phase wrap.
    localparam logic [3:0] CCU_PS_LAST16 = 4'hF;
    localparam logic [1:0] CCU_PS_LAST4  = 2'h3;
    localparam logic [1:0] CCU_PH_LAST   = 2'h3;
endpackage : ccu_pkg

// ### testbench/ccu_pin_model.sv
// Partner model: a signal source on the module pin that yields while the unit drives.
`timescale 1ns/1ps
`default_nettype none

module ccu_pin_model (
    input  wire logic src_lvl_i,
    input  wire logic pin_o_i,
    input  wire logic pin_oe_i,
    output logic      pin_wire_o
);
    // The source steps back while the unit drives, so the two never fight on the wire.
    assign pin_wire_o = pin_oe_i ? pin_o_i : src_lvl_i;
endmodule : ccu_pin_model

`default_nettype wire

// ### testbench/capture_compare_pwm_unit_tb_top.sv
// Self-checking bench for the capture/compare/PWM unit.
`timescale 1ns/1ps
`default_nettype none

module capture_compare_pwm_unit_tb_top;
    import ccu_pkg::*;
    logic        clk_i;
    logic        rst_i   = 1'b1;
    logic        cyc     = 1'b0;
    logic        stb     = 1'b0;
    logic        we      = 1'b0;
    logic [7:0]  adr     = 8'h00;
    logic [31:0] dat     = 32'h0000_0000;
    logic [15:0] tb      = 16'h0000;
    logic        src_lvl = 1'b0;
    logic [31:0] rdo;
    logic [31:0] rdat;
    logic        ack;
    logic        tclr;
    logic        adc_st;
    logic        irq;
    logic        pin_o;
    logic        pin_oe;
    logic        pin_w;
    logic        adc_en  = 1'b1;
    logic        adc_st_b;
    int          adc_b;
    int          fail_count = 0;
    int          checks     = 0;
    int          trig;
    int          adc;
    int          hi;
    int          pre;
    logic [3:0]  cmp_mode [6] = '{CCU_MODE_CMPHI, CCU_MODE_CMPLO, CCU_MODE_CMPHI, CCU_MODE_CMPIRQ, CCU_MODE_CMPTRG,
                                  CCU_MODE_CMPTRG};
    logic        cmp_pin  [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    logic [7:0]  pw_lo    [4] = '{8'h02, 8'h02, 8'h10, 8'h00};
    logic [1:0]  pw_ls    [4] = '{2'b00, 2'b01, 2'b00, 2'b00};
    int          pw_hi    [4] = '{32, 36, 64, 0};

    ccu_unit i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
        .wb_dat_i(dat), .wb_dat_o(rdo), .wb_ack_o(ack),
        .timebase_i(tb), .adc_enabled_i(adc_en), .timebase_clear_o(tclr), .adc_start_o(adc_st),
        .irq_o(irq), .pin_i(pin_w), .pin_o(pin_o), .pin_oe_o(pin_oe)
    );

    // Second unit shares bus and timebase so that its conversion start can be counted.
    ccu_unit #(.SECOND_UNIT(1'b1)) i_dut_b (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
        .wb_dat_i(dat), .wb_dat_o(), .wb_ack_o(),
        .timebase_i(tb), .adc_enabled_i(adc_en), .timebase_clear_o(), .adc_start_o(adc_st_b),
        .irq_o(), .pin_i(pin_w), .pin_o(), .pin_oe_o()
    );

    ccu_pin_model i_pin (.src_lvl_i(src_lvl), .pin_o_i(pin_o), .pin_oe_i(pin_oe), .pin_wire_o(pin_w));

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        if (fail_count == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // The request stands until ack is sampled high or 20 cycles pass; a slower answer ends the test as a failure.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= {24'h00_0000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rdat = rdo;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1) begin
            fail_count++;
            test_done();
        end
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask : wr

    task automatic rd(input string name, input logic [7:0] a, input logic [7:0] exp);
        xfer(1'b0, a, 8'h00);
        chk(name, rdat, {24'h00_0000, exp});
    endtask : rd

    task automatic cyc_n(input int n);
        repeat (n) @(posedge clk_i);
    endtask : cyc_n

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        rd("ctrl", CCU_OFF_CTRL, CCU_RST_CTRL);
        rd("period", CCU_OFF_PERIOD, CCU_RST_PERIOD);
        rd("pin", CCU_OFF_PIN, CCU_RST_PIN);
        rd("unmapped", 8'h20, 8'h00);
        chk("oe_rst", pin_oe, 1'b0);
        wr(CCU_OFF_CTRL, {4'h0, CCU_MODE_CAPR});
        tb <= 16'hA55A;
        src_lvl <= 1'b1;
        cyc_n(6);
        rd("val_lo", CCU_OFF_VALLO, 8'h5A);
        rd("val_hi", CCU_OFF_VALHI, 8'hA5);
        rd("flag", CCU_OFF_FLAG, 8'h04);
        tb <= 16'h1357;
        src_lvl <= 1'b0;
        cyc_n(6);
        rd("val_fall_ign", CCU_OFF_VALLO, 8'h5A);
        wr(CCU_OFF_CTRL, {4'h0, CCU_MODE_CAPF});
        src_lvl <= 1'b1;
        cyc_n(6);
        rd("val_rise_ign", CCU_OFF_VALLO, 8'h5A);
        src_lvl <= 1'b0;
        cyc_n(6);
        rd("val_ovr_lo", CCU_OFF_VALLO, 8'h57);
        rd("val_ovr_hi", CCU_OFF_VALHI, 8'h13);
        rd("flag_sticky", CCU_OFF_FLAG, 8'h04);
        for (int m = 0; m < 2; m++) begin
            pre = (m == 0) ? 4 : 16;
            wr(CCU_OFF_CTRL, 8'h00);
            wr(CCU_OFF_CTRL, {4'h0, (m == 0) ? CCU_MODE_CAP4 : CCU_MODE_CAP16});
            wr(CCU_OFF_FLAG, 8'h00);
            for (int e = 1; e <= pre; e++) begin
                if (e == pre) rd("flag_pre", CCU_OFF_FLAG, 8'h00);
                tb <= 16'(e);
                src_lvl <= 1'b1;
                cyc_n(4);
                src_lvl <= 1'b0;
                cyc_n(4);
            end
            rd("val_pre", CCU_OFF_VALLO, pre[7:0]);
            rd("flag_pre_hit", CCU_OFF_FLAG, 8'h04);
        end
        wr(CCU_OFF_PIN, 8'h00);
        wr(CCU_OFF_CTRL, {4'h0, CCU_MODE_CAPR});
        wr(CCU_OFF_FLAG, 8'h00);
        tb <= 16'h0246;
        wr(CCU_OFF_PIN, 8'h02);
        cyc_n(6);
        rd("val_port", CCU_OFF_VALLO, 8'h46);
        wr(CCU_OFF_IEN, 8'h04);
        cyc_n(2);
        chk("irq_on", irq, 1'b1);
        wr(CCU_OFF_VALLO, 8'h34);
        wr(CCU_OFF_VALHI, 8'h12);
        for (int i = 0; i < 6; i++) begin
            tb <= 16'h1233;
            adc_en <= (i != 5);
            if (i == 3) wr(CCU_OFF_CTRL, 8'h00);
            wr(CCU_OFF_CTRL, {4'h0, cmp_mode[i]});
            wr(CCU_OFF_FLAG, 8'h00);
            if (i == 3) chk("latch_off", pin_o, 1'b0);
            tb <= 16'h1234;
            trig = 0;
            adc = 0;
            adc_b = 0;
            for (int k = 0; k < 8; k++) begin
                @(posedge clk_i);
                trig += int'(tclr === 1'b1);
                adc += int'(adc_st === 1'b1);
                adc_b += int'(adc_st_b === 1'b1);
                if (tclr === 1'b1) tb <= 16'h0000;
            end
            chk("pin_cmp", pin_o, cmp_pin[i]);
            chk("trig", trig, int'(cmp_mode[i] == CCU_MODE_CMPTRG));
            chk("adc", adc, 0);
            chk("adc_b", adc_b, int'(cmp_mode[i] == CCU_MODE_CMPTRG && i != 5));
            chk("irq_cmp", irq, 1'b1);
            rd("flag_cmp", CCU_OFF_FLAG, 8'h04);
            wr(CCU_OFF_FLAG, 8'h00);
            rd("flag_once", CCU_OFF_FLAG, 8'h00);
        end
        rd("port_kept", CCU_OFF_PIN, 8'h02);
        wr(CCU_OFF_CTRL, 8'h00);
        wr(CCU_OFF_PERIOD, 8'h03);
        wr(CCU_OFF_PIN, 8'h06);
        for (int r = 0; r < 4; r++) begin
            wr(CCU_OFF_VALLO, pw_lo[r]);
            wr(CCU_OFF_CTRL, {2'b00, pw_ls[r], 4'hC});
            cyc_n(40);
            hi = 0;
            repeat (64) begin
                @(posedge clk_i);
                hi += int'(pin_o === 1'b1);
            end
            chk("pwm_high", hi, pw_hi[r]);
        end
        test_done();
    end
endmodule : capture_compare_pwm_unit_tb_top

`default_nettype wire
